// ---- mpt_dead.sv ----
// Purpose: Complementary pair with dead-time for one phase
// Assumes: Reference arrives on the system clock
// Notes: Brake forces both sides low without waiting
`timescale 1ns/10ps
module mpt_dead import mpt_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Reference, dead-time, brake
   input wire logic ref_in,
   input wire logic [DT_W-1:0] dead,
   input wire logic brake,
   // Gate outputs
   output logic high_side,
   output logic low_side
);
   // Delayed reference after dead-time elapses
   logic settled;
   // Dead-time counter
   logic [DT_W-1:0] dcnt;
   // Registered side states
   logic hs_q, ls_q;
   wire changed = (ref_in != settled);

   // Track reference, hold both off during the gap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settled <= 1'b0;
         dcnt <= DT_ZERO;
      end else if (!changed) begin
         dcnt <= DT_ZERO;
      end else if (dcnt >= dead) begin
         settled <= ref_in;
         dcnt <= DT_ZERO;
      end else begin
         dcnt <= dcnt + 8'h01;
      end
   end

   // Sides only on when settled and unchanged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_q <= 1'b0;
         ls_q <= 1'b0;
      end else begin
         hs_q <= settled && !changed;
         ls_q <= !settled && !changed;
      end
   end

   assign high_side = hs_q && !brake;
   assign low_side = ls_q && !brake;

   // Never both sides at once
   a_pair_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
      !(high_side && low_side))
      else $error("both sides of a phase active");
   // Brake clears both sides
   a_brake_off: assert property (@(posedge clk) disable iff (!rst_n)
      brake |-> (!high_side && !low_side))
      else $error("output active during brake");
endmodule

// ---- mpt_gate_model.sv ----
// Purpose: Behavioural half-bridge gate driver and power switches
// Assumes: Gate commands change only on the system clock
// Notes: Overlap of both sides is latched until reset
`timescale 1ns/10ps
module mpt_gate_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Gate commands per phase, A in bit 0
   input wire logic [2:0] low_cmd,
   input wire logic [2:0] high_cmd,
   // Phase node driven high, overlap seen
   output logic [2:0] node_high,
   output logic shoot_through
);
   // Node pulled up only by a lone high side
   assign node_high = high_cmd & ~low_cmd;

   // both sides on
   // Sticky, so a single overlapping cycle is not lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shoot_through <= 1'b0;
      end else if (|(low_cmd & high_cmd)) begin
         shoot_through <= 1'b1;
      end
   end
endmodule

// ---- mpt_pkg.sv ----
// Purpose: Constants shared by the motor PWM timer and its brake routing
// Assumes: One 25 MHz clock, asynchronous active-low reset
// Notes: No software registers; configuration arrives as plain ports
package mpt_pkg;
   // Counter and prescaler width
   localparam int CNT_W = 16;
   // Dead-time count width
   localparam int DT_W = 8;
   // Number of half-bridge phases
   localparam int PHASES = 3;
   // Pin map code that routes the outputs to the gate driver
   localparam logic [3:0] PIN_MAP_DRIVER = 4'h4;
   // Counter reset value
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // Dead-time reset value
   localparam logic [DT_W-1:0] DT_ZERO = 8'h00;
   // Clock monitor timeout, in system clock cycles, before failure
   localparam logic [7:0] SCM_LIMIT = 8'h10;
   // Counting direction states
   typedef enum logic [1:0] {
      MPT_DIR_UP = 2'b01,
      MPT_DIR_DOWN = 2'b10
   } mpt_dir_t;
endpackage

// ---- mpt_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of asynchronous levels
// Assumes: Inputs are levels, not pulses shorter than two clocks
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module mpt_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw and synchronised levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Metastability catch stage
   logic [W-1:0] meta;

   // Two stages, both cleared at reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ---- mpt_top.sv ----
// Purpose: Motor PWM timer with brake and comparator routing
// Assumes: Comparator and monitor inputs are asynchronous levels
// Notes: Configuration is held stable by the surrounding logic
`timescale 1ns/10ps
module mpt_top import mpt_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Timer configuration
   input wire logic enable,
   input wire logic center_mode,
   input wire logic count_down,
   input wire logic [CNT_W-1:0] prescale,
   input wire logic [CNT_W-1:0] reload,
   input wire logic [7:0] repeat_count,
   input wire logic [CNT_W-1:0] compare_a,
   input wire logic [CNT_W-1:0] compare_b,
   input wire logic [CNT_W-1:0] compare_c,
   input wire logic [DT_W-1:0] dead_time,
   input wire logic [3:0] motor_timer_pin_map,
   // Timer link
   input wire logic link_sync,
   output logic link_trigger,
   // Comparator results, general then current
   input wire logic [4:0] general_comparator,
   input wire logic [1:0] current_comparator,
   // Clock monitor
   input wire logic scm_enable,
   input wire logic monitored_clock_alive,
   input wire logic scm_flag_clear,
   output logic scm_fail_flag,
   // Routed comparator results
   output logic comparator_result_first,
   output logic motor_channel_four_input,
   output logic general_timer_channel_four_input,
   output logic system_reset_request,
   // Status
   output logic update_event,
   output logic brake_active,
   output logic [CNT_W-1:0] counter_value,
   // Gate driver pins
   output logic port_a_bit0,
   output logic port_a_bit2,
   output logic port_d_bit0,
   output logic port_a_bit3,
   output logic port_b_bit0,
   output logic port_b_bit1
);
   // Synchronised comparator, sync and monitor levels
   logic [4:0] gen_s;
   logic [1:0] cur_s;
   logic sync_s, alive_s;
   // Previous sync level for edge detect
   logic sync_d;
   // Prescaler and main counter
   logic [CNT_W-1:0] psc;
   logic [CNT_W-1:0] cnt;
   // Repetition down-counter
   logic [7:0] rep;
   // Current direction
   mpt_dir_t dir;
   // Clock monitor idle counter and last alive level
   logic [7:0] scm_cnt;
   logic alive_d;
   // PWM references, one per phase
   logic [PHASES-1:0] pwm_ref;
   logic [PHASES-1:0] hs, ls;
   // Registered routed outputs
   logic cmp_first_q, ch4_motor_q, ch4_gen_q, rst_req_q;

   // Comparator, link sync and clock-alive inputs pass two flops before any logic reads them;
   // brake response therefore lags the comparator pin by two clocks
   mpt_sync #(.W(5)) u_sync_gen (
      .clk(clk), .rst_n(rst_n), .d(general_comparator), .q(gen_s));
   mpt_sync #(.W(2)) u_sync_cur (
      .clk(clk), .rst_n(rst_n), .d(current_comparator), .q(cur_s));
   mpt_sync #(.W(2)) u_sync_misc (
      .clk(clk), .rst_n(rst_n),
      .d({link_sync, monitored_clock_alive}), .q({sync_s, alive_s}));

   // Decode of counter events
   wire psc_tick = (psc >= prescale);
   wire at_top = (cnt >= reload);
   wire at_zero = (cnt == CNT_ZERO);
   wire sync_rise = sync_s && !sync_d;
   // End of one full counter period
   wire period_end = psc_tick && (center_mode ?
      (dir == MPT_DIR_DOWN && cnt == 16'h0001) || (reload == CNT_ZERO) :
      (dir == MPT_DIR_UP ? at_top : at_zero));
   // Update only when repetition reaches zero
   wire next_update = enable && period_end && (rep == 8'h00);
   // Clock failure when no alive edge within limit
   wire scm_fail = scm_enable && (scm_cnt >= SCM_LIMIT);
   // Brake sources gathered
   wire brake_any = gen_s[3] || cur_s[0] || scm_fail;

   // Prescaler and link sync
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         psc <= CNT_ZERO;
         sync_d <= 1'b0;
      end else begin
         sync_d <= sync_s;
         // Prescaler restarts on tick or sync
         if (!enable || psc_tick || sync_rise)
            psc <= CNT_ZERO;
         else
            psc <= psc + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= CNT_ZERO;
         dir <= MPT_DIR_UP;
      end else if (!enable) begin
         dir <= count_down ? MPT_DIR_DOWN : MPT_DIR_UP;
      end else if (sync_rise) begin
         cnt <= (dir == MPT_DIR_DOWN && !center_mode) ? reload : CNT_ZERO;
      end else if (psc_tick) begin
         unique case (dir)
            MPT_DIR_UP: begin
               if (at_top) begin
                  if (center_mode) begin
                     dir <= MPT_DIR_DOWN;
                     cnt <= cnt - 16'h0001;
                  end else
                     cnt <= CNT_ZERO;
               end else
                  cnt <= cnt + 16'h0001;
            end
            MPT_DIR_DOWN: begin
               if (at_zero) begin
                  if (center_mode) begin
                     dir <= MPT_DIR_UP;
                     cnt <= cnt + 16'h0001;
                  end else
                     cnt <= reload;
               end else
                  cnt <= cnt - 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rep <= 8'h00;
         update_event <= 1'b0;
      end else begin
         update_event <= next_update;
         if (!enable)
            rep <= repeat_count;
         else if (period_end)
            rep <= (rep == 8'h00) ? repeat_count : rep - 8'h01;
      end
   end

   // Update pulse goes out as link trigger
   assign link_trigger = update_event;

   // Clock monitor watchdog on alive edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scm_cnt <= 8'h00;
         alive_d <= 1'b0;
         scm_fail_flag <= 1'b0;
      end else begin
         alive_d <= alive_s;
         if (!scm_enable || alive_s != alive_d)
            scm_cnt <= 8'h00;
         else if (scm_cnt < SCM_LIMIT)
            scm_cnt <= scm_cnt + 8'h01;
         // Set wins over clear
         if (scm_fail)
            scm_fail_flag <= 1'b1;
         else if (scm_flag_clear)
            scm_fail_flag <= 1'b0;
      end
   end

   // Edge-aligned or centred comparison per phase
   wire [CNT_W-1:0] cmp_sel [PHASES] = '{compare_a, compare_b, compare_c};
   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_phase
         assign pwm_ref[g] = enable && (cnt < cmp_sel[g]);
         mpt_dead u_dead (
            .clk(clk), .rst_n(rst_n), .ref_in(pwm_ref[g]),
            .dead(dead_time), .brake(brake_any),
            .high_side(hs[g]), .low_side(ls[g]));
      end
   endgenerate

   // Routed comparator results, registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_first_q <= 1'b0;
         ch4_motor_q <= 1'b0;
         ch4_gen_q <= 1'b0;
         rst_req_q <= 1'b0;
      end else begin
         // Only first result reaches a pin
         cmp_first_q <= gen_s[0];
         ch4_motor_q <= gen_s[1];
         ch4_gen_q <= gen_s[2];
         // Fifth general result resets; second current
         rst_req_q <= gen_s[4] || cur_s[1];
      end
   end
   // Routed results leave straight from their flops
   assign comparator_result_first = cmp_first_q;
   assign motor_channel_four_input = ch4_motor_q;
   assign general_timer_channel_four_input = ch4_gen_q;
   assign system_reset_request = rst_req_q;
   assign counter_value = cnt;

   assign brake_active = brake_any;

   // Driver pins live only under the driver pin map
   wire map_ok = (motor_timer_pin_map == PIN_MAP_DRIVER);
   // Low-side pins, then high-side; six PWM pins drive three bridges
   assign port_a_bit0 = map_ok && ls[0];
   assign port_a_bit2 = map_ok && ls[1];
   assign port_d_bit0 = map_ok && ls[2];
   assign port_a_bit3 = map_ok && hs[0];
   assign port_b_bit0 = map_ok && hs[1];
   assign port_b_bit1 = map_ok && hs[2];

   // Brake sequence: source then phase A pins off
   sequence s_brake_src;
      gen_s[3] || cur_s[0];
   endsequence
   a_brake_general: assert property (@(posedge clk) disable iff (!rst_n)
      gen_s[3] |-> brake_active)
      else $error("general comparator did not brake");
   a_brake_current: assert property (@(posedge clk) disable iff (!rst_n)
      cur_s[0] |-> brake_active)
      else $error("current comparator did not brake");
   a_brake_pins_off: assert property (@(posedge clk) disable iff (!rst_n)
      s_brake_src |-> !(port_a_bit3 || port_a_bit0))
      else $error("pins active during brake");
   a_reset_fifth: assert property (@(posedge clk) disable iff (!rst_n)
      gen_s[4] |=> system_reset_request)
      else $error("fifth result did not reset");
   a_reset_current: assert property (@(posedge clk) disable iff (!rst_n)
      cur_s[1] |=> system_reset_request)
      else $error("current result did not reset");
   a_ch4_route: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 motor_channel_four_input == $past(gen_s[1]))
      else $error("channel four routing wrong");
   a_first_pin: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 comparator_result_first == $past(gen_s[0]))
      else $error("first result not on pin");
   // Clock loss: brake at once, flag from the next edge on
   sequence s_clock_lost;
      scm_fail;
   endsequence
   a_scm_flag: assert property (@(posedge clk) disable iff (!rst_n)
      s_clock_lost |=> scm_fail_flag)
      else $error("clock failure not flagged");
   // Heartbeat may resume at the next edge, so brake is checked now
   a_scm_brake: assert property (@(posedge clk) disable iff (!rst_n)
      s_clock_lost |-> brake_active)
      else $error("clock failure did not brake");
   a_update_rep: assert property (@(posedge clk) disable iff (!rst_n)
      update_event |-> $past(rep) == 8'h00)
      else $error("update before repetition done");
   a_phase_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(port_a_bit0 && port_a_bit3))
      else $error("phase one shoot-through");
   a_phase_b_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(port_a_bit2 && port_b_bit0))
      else $error("phase two shoot-through");
   a_phase_c_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(port_d_bit0 && port_b_bit1))
      else $error("phase three shoot-through");

   // Any of the six driver pins high, for the checks below
   wire pins_any = port_a_bit0 || port_a_bit2 || port_d_bit0 ||
      port_a_bit3 || port_b_bit0 || port_b_bit1;
   // Any brake source leaves every driver pin low, all three phases
   a_brake_all_low: assert property (@(posedge clk) disable iff (!rst_n)
      brake_active |-> !pins_any)
      else $error("driver pin active during brake");
   // A wrong pin map keeps the gate driver dark
   a_map_all_low: assert property (@(posedge clk) disable iff (!rst_n)
      !map_ok |-> !pins_any)
      else $error("driver pin active under wrong map");
   // Third general result reaches the general timer channel four
   a_ch4_general: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 general_timer_channel_four_input == $past(gen_s[2]))
      else $error("general timer channel four routing wrong");
endmodule

// ---- tb_motor_pwm_timer_brake_routing.sv ----
// Purpose: Self-checking bench for the motor PWM timer and routing
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes: Waits of three edges cover the two-flop input synchronisers
`timescale 1ns/10ps
module tb_motor_pwm_timer_brake_routing import mpt_pkg::*;;
   // Stimulus
   logic clk, rst_n, enable, alive, hb_run, scm_enable, scm_flag_clear;
   logic center, count_dn, sync;
   logic [CNT_W-1:0] prescale, reload, cmp_a, cmp_b, cmp_c;
   logic [7:0] repeat_count;
   logic [DT_W-1:0] dead_time;
   logic [3:0] pin_map;
   logic [4:0] gen_cmp;
   logic [1:0] cur_cmp;
   // Observed outputs
   logic link_trigger, scm_fail_flag, res_first, ch4_motor, ch4_gen;
   logic sys_rst_req, update_event, brake_active, shoot;
   logic [CNT_W-1:0] counter_value;
   // Low A,B,C then high A,B,C
   logic [5:0] pins;
   logic [2:0] node_high;
   int errors, tests_run;

   mpt_top DUT (.clk(clk), .rst_n(rst_n), .enable(enable),
      .center_mode(center), .count_down(count_dn), .prescale(prescale),
      .reload(reload), .repeat_count(repeat_count), .compare_a(cmp_a),
      .compare_b(cmp_b), .compare_c(cmp_c), .dead_time(dead_time),
      .motor_timer_pin_map(pin_map), .link_sync(sync),
      .link_trigger(link_trigger), .general_comparator(gen_cmp),
      .current_comparator(cur_cmp), .scm_enable(scm_enable),
      .monitored_clock_alive(alive), .scm_flag_clear(scm_flag_clear),
      .scm_fail_flag(scm_fail_flag), .comparator_result_first(res_first),
      .motor_channel_four_input(ch4_motor),
      .general_timer_channel_four_input(ch4_gen),
      .system_reset_request(sys_rst_req), .update_event(update_event),
      .brake_active(brake_active), .counter_value(counter_value),
      .port_a_bit0(pins[5]), .port_a_bit2(pins[4]), .port_d_bit0(pins[3]),
      .port_a_bit3(pins[2]), .port_b_bit0(pins[1]), .port_b_bit1(pins[0]));

   mpt_gate_model bridge (.clk(clk), .rst_n(rst_n),
      .low_cmd({pins[3], pins[4], pins[5]}),
      .high_cmd({pins[0], pins[1], pins[2]}),
      .node_high(node_high), .shoot_through(shoot));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Heartbeat of the monitored clock, stopped to fake a failure
   always @(posedge clk) begin
      #1 if (hb_run) alive = ~alive;
   end

   // Compare and count; four-state so X never matches
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Advance n edges, land just after the last
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Verdict, reached from the sequence or the watchdog
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Comparator results routed one at a time
   task automatic t_route();
      for (int i = 0; i < 5; i++) begin
         gen_cmp = 5'h01 << i;
         tick(3);
         check("routed", {res_first, ch4_motor, ch4_gen, sys_rst_req},
               (i == 4) ? 16'h1 : (i == 3) ? 16'h0 : 16'h8 >> i);
         check("general brake", brake_active, 16'(i == 3));
      end
      gen_cmp = 5'h00;
      for (int j = 0; j < 2; j++) begin
         cur_cmp = 2'h1 << j;
         tick(3);
         check("current brake", brake_active, 16'(j == 0));
         check("current reset", sys_rst_req, 16'(j == 1));
      end
      cur_cmp = 2'h0;
      tick(3);
      $display("test routing done");
   endtask

   // Update spacing: up at prescale 0 and 1, then down, then centred
   task automatic t_update();
      int n;
      logic [CNT_W-1:0] mx;
      logic lk;
      for (int p = 0; p < 4; p++) begin
         enable = 1'b0;
         prescale = 16'(p == 1);
         count_dn = (p == 2);
         center = (p == 3);
         tick(2);
         enable = 1'b1;
         n = 0;
         while (update_event !== 1'b1 && n < 200) begin
            tick(1);
            n++;
         end
         lk = link_trigger;
         tick(1);
         lk = lk | link_trigger;
         check("link trigger", lk, 16'h1);
         n = 0;
         mx = 16'h0000;
         while (update_event !== 1'b1 && n < 200) begin
            if (counter_value > mx) mx = counter_value;
            tick(1);
            n++;
         end
         // Two periods of ten ticks, twenty at prescale 1, or eighteen when centred
         check("update spacing", 16'(n + 1), (p == 3) ? 16'h24 :
               (p == 1) ? 16'h28 : 16'h14);
         check("counter top", mx, reload);
      end
      $display("test update done");
   endtask

   // Link sync restarts the counter mid-period
   task automatic t_sync();
      enable = 1'b0;
      center = 1'b0;
      prescale = 16'h0000;
      tick(2);
      enable = 1'b1;
      tick(5);
      sync = 1'b1;
      tick(3);
      check("sync restart", counter_value, 16'h0000);
      sync = 1'b0;
      tick(4);
      check("sync count", counter_value, 16'h0004);
      $display("test sync done");
   endtask

   // Pin mapping, map refusal, brake, dead-time gap
   task automatic t_pins();
      int gap;
      tick(20);
      check("pins", pins, 16'h2A);
      check("bridge", node_high, 16'h2);
      pin_map = 4'h3;
      tick(1);
      check("pins bad map", pins, 16'h0);
      pin_map = 4'h4;
      gen_cmp = 5'h08;
      tick(3);
      check("pins braked", pins, 16'h0);
      gen_cmp = 5'h00;
      tick(20);
      cmp_a = 16'hFFFF;
      gap = 0;
      while (pins[2] !== 1'b1 && gap < 50) begin
         tick(1);
         if (pins[5] === 1'b0 && pins[2] === 1'b0) gap++;
      end
      check("dead end", pins[2], 16'h1);
      check("dead gap", 16'(gap >= int'(dead_time) &&
            gap <= int'(dead_time) + 2), 16'h1);
      $display("test pins done");
   endtask

   // Clock monitor: ignored when off, brakes and flags when on
   task automatic t_monitor();
      int n;
      hb_run = 1'b0;
      tick(30);
      check("monitor off", {brake_active, scm_fail_flag}, 16'h0);
      hb_run = 1'b1;
      scm_enable = 1'b1;
      tick(6);
      hb_run = 1'b0;
      n = 0;
      while (brake_active !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      check("monitor brake", 16'(n >= 16 && n < 40), 16'h1);
      tick(1);
      check("monitor flag", scm_fail_flag, 16'h1);
      check("monitor pins", pins, 16'h0);
      scm_flag_clear = 1'b1;
      tick(1);
      scm_flag_clear = 1'b0;
      tick(1);
      check("flag held", scm_fail_flag, 16'h1);
      hb_run = 1'b1;
      tick(8);
      check("brake gone", brake_active, 16'h0);
      scm_flag_clear = 1'b1;
      tick(1);
      scm_flag_clear = 1'b0;
      tick(1);
      check("flag cleared", scm_fail_flag, 16'h0);
      $display("test monitor done");
   endtask

   // Main sequence
   initial begin
      {enable, alive, scm_enable, scm_flag_clear} = 4'h0;
      {center, count_dn, sync} = 3'h0;
      {errors, tests_run} = 0;
      hb_run = 1'b1;
      rst_n = 1'b0;
      prescale = 16'h0000;
      reload = 16'h0009;
      repeat_count = 8'h01;
      cmp_a = 16'h0000;
      cmp_b = 16'hFFFF;
      cmp_c = 16'h0000;
      dead_time = 8'h04;
      pin_map = 4'h4;
      gen_cmp = 5'h00;
      cur_cmp = 2'h0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      check("after reset", {pins, sys_rst_req, update_event}, 16'h0);
      t_route();
      t_update();
      t_sync();
      t_pins();
      t_monitor();
      check("no overlap", shoot, 16'h0);
      end_sim();
   end

   // Watchdog well past the expected run length
   initial begin
      #(40 * 20000);
      errors++;
      $display("watchdog expired");
      end_sim();
   end
endmodule
